// File: adp_pkg.sv
// Constants and types of the audio playback engine.
// Operation
// - One word fetch per channel per line.
// - Single word buffer sustains 28,867 samples/second.
// - NTSC countdown tick is 279.365 ns.
// - PAL countdown tick is 0.281937 us.
// - Late fetch at expiry repeats previous sample.
// - Period register sets ticks between samples.
// - Started channel loops until enable cleared.
// - Each replay restarts at current location registers.
// - Location held as 3-bit high, 15-bit low.
// - Word count gives words before repeating.
// - No fetch while master enable bit 9 clear.
// - Fetch needs master and channel enable bits 0-3.
// - Write with bit 15 set sets ones.
// - Disable stops; enable restarts from first word.
// - Brief disable may resume; either outcome allowed.
// - Period counts per tick; zero takes sample.
// - Lower-address byte of each word plays first.
// - Volume 0 to 64 scales channel output.
// - Reload event pulses after working copies load.
package adp_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          NUM_CH          = 4;
    localparam int          DEC_W           = 12;
    localparam logic [11:0] OFS_DMA_CONTROL = 12'h000;
    localparam logic [11:0] OFS_CONFIG      = 12'h004;
    localparam logic [11:0] OFS_STATUS      = 12'h008;
    localparam logic [11:0] CH_BASE         = 12'h080;
    localparam logic [11:0] CH_REGION_MASK  = 12'hf80;
    localparam logic [11:0] CH_SUB_MASK     = 12'h01f;
    localparam int          CH_SEL_LSB      = 5;
    localparam logic [11:0] OFS_START_HIGH  = 12'h000;
    localparam logic [11:0] OFS_START_LOW   = 12'h004;
    localparam logic [11:0] OFS_WORD_COUNT  = 12'h008;
    localparam logic [11:0] OFS_PERIOD      = 12'h00c;
    localparam logic [11:0] OFS_VOLUME      = 12'h010;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int          BIT_SET_OR_CLEAR_SELECT     = 15;
    localparam int          BIT_MASTER      = 9;
    localparam int          CFG_PAL_BIT     = 0;
    localparam logic [15:0] CTRL_MASK       = 16'h020f;
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam logic [6:0]  VOL_MAX         = 7'h40;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam real         CLK_PERIOD_NS   = 50.0;
    localparam real         NTSC_TICK_NS    = 279.365;
    localparam real         PAL_TICK_US     = 0.281937;
    localparam int          NTSC_CLOCK_CONSTANT = 3579545;
    localparam int          PAL_CLOCK_CONSTANT  = 3546895;
    localparam int          MAX_SAMPLE_RATE = 28867;
    localparam int          ACC_W           = 19;
    localparam logic [18:0] ACC_STEP        = 19'(int'(CLK_PERIOD_NS * 1000.0));
    localparam logic [18:0] NTSC_TICK_PS    = 19'(int'(NTSC_TICK_NS * 1000.0));
    localparam logic [18:0] PAL_TICK_PS     = 19'(int'(PAL_TICK_US * 1.0e6));
    localparam logic [15:0] MIN_PERIOD      = 16'(NTSC_CLOCK_CONSTANT / MAX_SAMPLE_RATE);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        CH_IDLE = 2'h0,
        CH_LOAD = 2'h1,
        CH_RUN  = 2'h3
    } adp_ch_state_t;

    typedef struct packed {
        adp_ch_state_t st;
        logic [17:0]   ptr;
        logic [15:0]   left;
        logic [15:0]   cnt;
        logic [15:0]   buf_word;
        logic          buf_full;
        logic [15:0]   play_word;
        logic          phase;
        logic          req;
        logic          reload;
        logic [7:0]    sample;
        logic [14:0]   level;
    } adp_ch_reg_t;

    typedef struct packed {
        logic [15:0]       ctrl;
        logic              pal;
        logic [3:0][2:0]   start_high;
        logic [3:0][14:0]  start_low;
        logic [3:0][15:0]  word_count;
        logic [3:0][15:0]  period;
        logic [3:0][6:0]   volume;
        logic              dp_write;
        logic              wr_wait;
        logic [11:0]       dp_addr;
        logic [31:0]       rdata;
        logic [18:0]       acc;
        logic              tick;
        logic              busy;
        logic [1:0]        owner;
        logic [18:0]       mem_addr;
    } adp_top_reg_t;

endpackage

// File: adp_channel.sv
// One audio playback channel.
`timescale 1ns/100ps
module adp_channel (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        run_en,
    input  logic        tick,
    input  logic        line_slot,
    input  logic [2:0]  start_high,
    input  logic [14:0] start_low,
    input  logic [15:0] word_count,
    input  logic [15:0] period,
    input  logic [6:0]  volume,
    input  logic        fetch_ack,
    input  logic [15:0] fetch_data,
    output logic        fetch_req,
    output logic [17:0] fetch_addr,
    output logic        reload_evt,
    output logic        active,
    output logic [14:0] level
);

    adp_pkg::adp_ch_reg_t s_r;
    adp_pkg::adp_ch_reg_t s_nxt;
    logic [6:0]           vol_eff;
    logic signed [15:0]   prod;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.reload = 1'b0;
        vol_eff      = (volume > adp_pkg::VOL_MAX) ? adp_pkg::VOL_MAX : volume;
        prod         = '0;
        case (s_r.st)
            adp_pkg::CH_IDLE:
            begin
                s_nxt.req    = 1'b0;
                s_nxt.sample = '0;
                if (run_en)
                begin
                    s_nxt.st = adp_pkg::CH_LOAD;
                end
            end
            adp_pkg::CH_LOAD:
            begin
                // Every start copies the location registers.
                s_nxt.ptr      = {start_high, start_low};
                s_nxt.left     = word_count;
                s_nxt.cnt      = period;
                s_nxt.buf_full = 1'b0;
                s_nxt.phase    = 1'b0;
                s_nxt.reload   = 1'b1;
                s_nxt.st       = run_en ? adp_pkg::CH_RUN : adp_pkg::CH_IDLE;
            end
            adp_pkg::CH_RUN:
            begin
                if (!run_en)
                begin
                    // Stopping is immediate, so a short disable always restarts.
                    s_nxt.st  = adp_pkg::CH_IDLE;
                    s_nxt.req = 1'b0;
                end
                else
                begin
                    if (s_r.req)
                    begin
                        if (fetch_ack)
                        begin
                            s_nxt.buf_word = fetch_data;
                            s_nxt.buf_full = 1'b1;
                            s_nxt.req      = 1'b0;
                            if (s_r.left <= 16'h0001)
                            begin
                                s_nxt.ptr    = {start_high, start_low};
                                s_nxt.left   = word_count;
                                s_nxt.reload = 1'b1;
                            end
                            else
                            begin
                                s_nxt.ptr  = s_r.ptr + 18'h00001;
                                s_nxt.left = s_r.left - 16'h0001;
                            end
                        end
                    end
                    else if (!s_r.buf_full && line_slot)
                    begin
                        s_nxt.req = 1'b1;
                    end
                    if (tick)
                    begin
                        if (s_r.cnt <= 16'h0001)
                        begin
                            s_nxt.cnt = period;
                            if (s_r.phase)
                            begin
                                s_nxt.sample = s_r.play_word[7:0];
                                s_nxt.phase  = 1'b0;
                            end
                            else if (s_r.buf_full)
                            begin
                                s_nxt.play_word = s_r.buf_word;
                                s_nxt.sample    = s_r.buf_word[15:8];
                                s_nxt.phase     = 1'b1;
                                s_nxt.buf_full  = 1'b0;
                            end
                            // Otherwise the old sample stays.
                        end
                        else
                        begin
                            s_nxt.cnt = s_r.cnt - 16'h0001;
                        end
                    end
                end
            end
            default:
            begin
                s_nxt.st = adp_pkg::CH_IDLE;
            end
        endcase
        prod        = $signed(s_nxt.sample) * $signed({1'b0, vol_eff});
        s_nxt.level = prod[14:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign fetch_req  = s_r.req;
    assign fetch_addr = s_r.ptr;
    assign reload_evt = s_r.reload;
    assign active     = (s_r.st != adp_pkg::CH_IDLE);
    assign level      = s_r.level;

endmodule // adp_channel

// File: adp_audio_dma.sv
// Top of the audio playback engine.
`timescale 1ns/100ps
module adp_audio_dma (
    input  logic             hclk,
    input  logic             hresetn,
    input  logic             hsel,
    input  logic [31:0]      haddr,
    input  logic [1:0]       htrans,
    input  logic             hwrite,
    input  logic [2:0]       hsize,
    input  logic [31:0]      hwdata,
    input  logic             hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  logic [3:0]       line_slot,
    input  logic             mem_ack,
    input  logic [15:0]      mem_rdata,
    output logic             mem_req,
    output logic [18:0]      mem_addr,
    output logic [3:0]       channel_reload,
    output logic [3:0]       channel_active,
    output logic [3:0][14:0] channel_level
);

    adp_pkg::adp_top_reg_t s_r;
    adp_pkg::adp_top_reg_t s_nxt;

    logic              addr_ok;
    logic              master_en;
    logic [3:0]        run_en;
    logic [3:0]        ch_req;
    logic [3:0][17:0]  ch_addr;
    logic [3:0]        ch_ack;
    logic [3:0]        period_short;
    logic              pick_any;
    logic [1:0]        pick;
    logic [18:0]       acc_sum;
    logic [18:0]       tick_len;
    logic [11:0]       a_dec;
    logic [1:0]        rd_ch;
    logic [11:0]       rd_sub;
    logic [1:0]        dp_ch;
    logic [11:0]       dp_sub;
    logic [31:0]       rd_val;

    // ****************************************************************
    // Enables and address fields
    // ****************************************************************
    assign master_en = s_r.ctrl[adp_pkg::BIT_MASTER];
    assign a_dec     = haddr[adp_pkg::DEC_W-1:0];
    assign rd_ch     = a_dec[adp_pkg::CH_SEL_LSB +: 2];
    assign rd_sub    = a_dec & adp_pkg::CH_SUB_MASK;
    assign dp_ch     = s_r.dp_addr[adp_pkg::CH_SEL_LSB +: 2];
    assign dp_sub    = s_r.dp_addr & adp_pkg::CH_SUB_MASK;
    assign addr_ok   = hsel && hready && htrans[1] && (hsize == adp_pkg::HSIZE_WORD);

    // ****************************************************************
    // Channels
    // ****************************************************************
    generate
        for (genvar g = 0; g < adp_pkg::NUM_CH; g++)
        begin : g_ch
            assign run_en[g]       = master_en && s_r.ctrl[g];
            assign ch_ack[g]       = mem_ack && s_r.busy && (s_r.owner == 2'(g));
            assign period_short[g] = (s_r.period[g] < adp_pkg::MIN_PERIOD);

            adp_channel u_ch (
                .hclk       (hclk),
                .hresetn    (hresetn),
                .run_en     (run_en[g]),
                .tick       (s_r.tick),
                .line_slot  (line_slot[g]),
                .start_high (s_r.start_high[g]),
                .start_low  (s_r.start_low[g]),
                .word_count (s_r.word_count[g]),
                .period     (s_r.period[g]),
                .volume     (s_r.volume[g]),
                .fetch_ack  (ch_ack[g]),
                .fetch_data (mem_rdata),
                .fetch_req  (ch_req[g]),
                .fetch_addr (ch_addr[g]),
                .reload_evt (channel_reload[g]),
                .active     (channel_active[g]),
                .level      (channel_level[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Read multiplexer for the address phase
    // ****************************************************************
    always_comb
    begin
        rd_val = '0;
        if (a_dec == adp_pkg::OFS_DMA_CONTROL)
        begin
            rd_val[15:0] = s_r.ctrl;
        end
        else if (a_dec == adp_pkg::OFS_CONFIG)
        begin
            rd_val[adp_pkg::CFG_PAL_BIT] = s_r.pal;
        end
        else if (a_dec == adp_pkg::OFS_STATUS)
        begin
            rd_val[7:0] = {period_short, channel_active};
        end
        else if ((a_dec & adp_pkg::CH_REGION_MASK) == adp_pkg::CH_BASE)
        begin
            if (rd_sub == adp_pkg::OFS_START_HIGH)
            begin
                rd_val[2:0] = s_r.start_high[rd_ch];
            end
            else if (rd_sub == adp_pkg::OFS_START_LOW)
            begin
                rd_val[15:0] = {s_r.start_low[rd_ch], 1'b0};
            end
            else if (rd_sub == adp_pkg::OFS_WORD_COUNT)
            begin
                rd_val[15:0] = s_r.word_count[rd_ch];
            end
            else if (rd_sub == adp_pkg::OFS_PERIOD)
            begin
                rd_val[15:0] = s_r.period[rd_ch];
            end
            else if (rd_sub == adp_pkg::OFS_VOLUME)
            begin
                rd_val[6:0] = s_r.volume[rd_ch];
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_nxt    = s_r;
        pick_any = 1'b0;
        pick     = 2'h0;
        tick_len = s_r.pal ? adp_pkg::PAL_TICK_PS : adp_pkg::NTSC_TICK_PS;
        acc_sum  = s_r.acc + adp_pkg::ACC_STEP;

        // A write lands in its first data cycle,
        // so a back-to-back read sees it.
        if (s_r.dp_write && !s_r.wr_wait)
        begin
            s_nxt.wr_wait = 1'b1;
            if (s_r.dp_addr == adp_pkg::OFS_DMA_CONTROL)
            begin
                if (hwdata[adp_pkg::BIT_SET_OR_CLEAR_SELECT])
                begin
                    s_nxt.ctrl = s_r.ctrl | (hwdata[15:0] & adp_pkg::CTRL_MASK);
                end
                else
                begin
                    s_nxt.ctrl = s_r.ctrl & ~(hwdata[15:0] & adp_pkg::CTRL_MASK);
                end
            end
            else if (s_r.dp_addr == adp_pkg::OFS_CONFIG)
            begin
                s_nxt.pal = hwdata[adp_pkg::CFG_PAL_BIT];
            end
            else if ((s_r.dp_addr & adp_pkg::CH_REGION_MASK) == adp_pkg::CH_BASE)
            begin
                if (dp_sub == adp_pkg::OFS_START_HIGH)
                begin
                    s_nxt.start_high[dp_ch] = hwdata[2:0];
                end
                else if (dp_sub == adp_pkg::OFS_START_LOW)
                begin
                    s_nxt.start_low[dp_ch] = hwdata[15:1];
                end
                else if (dp_sub == adp_pkg::OFS_WORD_COUNT)
                begin
                    s_nxt.word_count[dp_ch] = hwdata[15:0];
                end
                else if (dp_sub == adp_pkg::OFS_PERIOD)
                begin
                    s_nxt.period[dp_ch] = hwdata[15:0];
                end
                else if (dp_sub == adp_pkg::OFS_VOLUME)
                begin
                    s_nxt.volume[dp_ch] = hwdata[6:0];
                end
            end
        end
        else if (s_r.dp_write)
        begin
            s_nxt.dp_write = 1'b0;
            s_nxt.wr_wait  = 1'b0;
        end

        if (addr_ok && hwrite)
        begin
            s_nxt.dp_write = 1'b1;
            s_nxt.wr_wait  = 1'b0;
            s_nxt.dp_addr  = a_dec;
        end
        if (hready)
        begin
            s_nxt.rdata = (addr_ok && !hwrite) ? rd_val : '0;
        end

        // The tick is not a whole number of clocks.
        if (acc_sum >= tick_len)
        begin
            s_nxt.acc  = acc_sum - tick_len;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.acc  = acc_sum;
            s_nxt.tick = 1'b0;
        end

        for (int i = adp_pkg::NUM_CH - 1; i >= 0; i--)
        begin
            if (ch_req[i])
            begin
                pick_any = 1'b1;
                pick     = 2'(i);
            end
        end
        if (s_r.busy)
        begin
            if (mem_ack)
            begin
                s_nxt.busy = 1'b0;
            end
        end
        else if (pick_any && master_en)
        begin
            s_nxt.busy     = 1'b1;
            s_nxt.owner    = pick;
            s_nxt.mem_addr = {ch_addr[pick], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r      <= '0;
            s_r.ctrl <= adp_pkg::CTRL_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign hreadyout = !(s_r.dp_write && !s_r.wr_wait);
    assign hresp     = 1'b0;
    assign hrdata    = s_r.rdata;
    assign mem_req   = s_r.busy;
    assign mem_addr  = s_r.mem_addr;

endmodule // adp_audio_dma

// File: adp_mem_model.sv
// Memory and line slot model of the audio engine.
`timescale 1ns/100ps
module adp_mem_model #(
    parameter int LINE = 40
) (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        mem_req,
    input  logic [18:0] mem_addr,
    input  logic [7:0]  ack_delay,
    output logic        mem_ack,
    output logic [15:0] mem_rdata,
    output logic [3:0]  line_slot
);
    // ****
    // Slots and answers
    // ****
    logic [18:0] addr_q[$];
    logic [7:0]  wt;
    int          cnt;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt       <= 0;
            wt        <= 8'h0;
            line_slot <= 4'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0;
        end
        else
        begin
            cnt       <= (cnt == LINE - 1) ? 0 : cnt + 1;
            line_slot <= (cnt < 4) ? 4'h1 << cnt[1:0] : 4'h0;
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
            begin
                wt <= wt + 8'h1;
                if (wt >= ack_delay)
                begin
                    wt        <= 8'h0;
                    mem_ack   <= 1'b1;
                    mem_rdata <= {4'h1, mem_addr[4:1], 4'hf, mem_addr[4:1]};
                    addr_q.push_back(mem_addr);
                end
            end
        end
    end
endmodule // adp_mem_model

// File: adp_audio_dma_asserts.sv
// Port checker of the audio playback engine.
`timescale 1ns/100ps
module adp_audio_dma_asserts (
    input logic             hclk,
    input logic             hresetn,
    input logic             hsel,
    input logic [1:0]       htrans,
    input logic             hwrite,
    input logic [2:0]       hsize,
    input logic             hready,
    input logic [31:0]      hrdata,
    input logic             hreadyout,
    input logic             mem_req,
    input logic [18:0]      mem_addr,
    input logic             mem_ack,
    input logic [3:0]       channel_reload,
    input logic [3:0]       channel_active,
    input logic [3:0][14:0] channel_level
);
    // ****
    // Properties
    // ****
    logic tk;
    logic rd_ph;

    assign tk = hsel && hready && htrans[1] && hsize == adp_pkg::HSIZE_WORD;

    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            rd_ph <= 1'b0;
        else
            rd_ph <= tk && !hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_wr_wait; tk && hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_wr_wait: assert property (p_wr_wait) else $error("write wait");
    property p_rd_fast; tk && !hwrite |=> hreadyout; endproperty
    a_rd_fast: assert property (p_rd_fast) else $error("read wait");
    property p_rd_idle; !rd_ph |-> hrdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_mem_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("fetch dropped early");
    property p_mem_drop; mem_req && mem_ack |=> !mem_req; endproperty
    a_mem_drop: assert property (p_mem_drop) else $error("fetch held");
    property p_mem_align; mem_req |-> !mem_addr[0]; endproperty
    a_mem_align: assert property (p_mem_align) else $error("fetch unaligned");
    property p_rel_act; |channel_reload |-> (channel_reload & ~channel_active) == 4'h0; endproperty
    a_rel_act: assert property (p_rel_act) else $error("idle reload");
    property p_rel_one; channel_reload[0] |=> !channel_reload[0]; endproperty
    a_rel_one: assert property (p_rel_one) else $error("long reload");
    property p_lvl_off; !channel_active[0] [*2] |-> channel_level[0] == 15'h0; endproperty
    a_lvl_off: assert property (p_lvl_off) else $error("idle not silent");

    c_wr: cover property (tk && hwrite);
    c_fetch: cover property (mem_req && mem_ack);
    c_reload: cover property (channel_reload[0]);
endmodule // adp_audio_dma_asserts

bind adp_audio_dma adp_audio_dma_asserts adp_audio_dma_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .channel_reload(channel_reload), .channel_active(channel_active),
    .channel_level(channel_level)
);

// File: tb_audio_dma_channel_playback.sv
// Self-checking bench of the audio playback engine.
`timescale 1ns/100ps
module tb_audio_dma_channel_playback;
    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel = 1'b0;
    logic [31:0]      haddr = 32'h0;
    logic [1:0]       htrans = 2'h0;
    logic             hwrite = 1'b0;
    logic [2:0]       hsize = adp_pkg::HSIZE_WORD;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic [3:0]       line_slot;
    logic             mem_ack;
    logic [15:0]      mem_rdata;
    logic             mem_req;
    logic [18:0]      mem_addr;
    logic [3:0]       channel_reload;
    logic [3:0]       channel_active;
    logic [3:0][14:0] channel_level;
    logic [7:0]       ack_delay = 8'h2;
    logic [31:0]      r;
    logic [18:0]      base;
    logic [14:0]      a;
    logic [14:0]      b;
    logic [31:0]      cv [5] = '{32'h1, 32'h10, 32'h3, 32'd124, 32'h3};
    int               fails = 0;
    int               check_count = 0;
    int               cyc = 0;
    int               n;
    int               i;

    always #25 hclk = ~hclk;

    adp_audio_dma adp_audio_dma_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .line_slot(line_slot),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_addr(mem_addr),
        .channel_reload(channel_reload), .channel_active(channel_active),
        .channel_level(channel_level)
    );

    adp_mem_model adp_mem_model_i (
        .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .ack_delay(ack_delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .line_slot(line_slot)
    );

    // ****
    // Tasks and sequence
    // ****
    task give_verdict;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task ahb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, ad};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task gap(output int k, output logic [14:0] x, output logic [14:0] y);
        k = 0;
        x = channel_level[0];
        while (channel_level[0] === x) @(negedge hclk);
        x = channel_level[0];
        while (channel_level[0] === x) begin @(negedge hclk); k++; end
        y = channel_level[0];
        @(posedge hclk);
    endtask

    task fetched(input int k);
        while (adp_mem_model_i.addr_q.size() < k) @(posedge hclk);
    endtask

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            give_verdict;
        end
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, 12'h000, 0);
        chk(r, {16'h0, adp_pkg::CTRL_RESET});
        ahb(0, 12'h7f0, 0);
        chk(r, 32'h0);
        ahb(1, 12'h000, 32'h800f);
        ahb(0, 12'h000, 0);
        chk(r, 32'h000f);
        ahb(1, 12'h000, 32'h000a);
        ahb(0, 12'h000, 0);
        chk(r, 32'h0005);
        repeat (200) @(posedge hclk);
        chk(32'(adp_mem_model_i.addr_q.size()), 32'h0);
        chk(32'(channel_active), 32'h0);
        ahb(1, 12'h000, 32'h0005);
        for (i = 0; i < 5; i++)
        begin
            ahb(1, 12'h080 + 12'(4 * i), cv[i]);
            ahb(0, 12'h080 + 12'(4 * i), 0);
            chk(r, cv[i]);
        end
        base = 19'h10010;
        ahb(1, 12'h000, 32'h8201);
        gap(n, a, b);
        chk(32'(a), 32'h0048);
        chk(32'(b), 32'h7fe8);
        chk(32'(n >= 691 && n <= 694), 32'h1);
        ahb(1, 12'h004, 32'h1);
        gap(n, a, b);
        chk(32'(n >= 698 && n <= 701), 32'h1);
        ahb(0, 12'h008, 0);
        chk(r, 32'h00e1);
        fetched(7);
        for (i = 0; i < 7; i++)
            chk(32'(adp_mem_model_i.addr_q[i]), 32'(base + 19'(2 * (i % 3))));
        ahb(1, 12'h084, 32'h40);
        base = 19'h10040;
        while (channel_reload[0] !== 1'b1) @(negedge hclk);
        repeat (3) @(posedge hclk);
        adp_mem_model_i.addr_q.delete();
        ack_delay <= 8'd30;
        fetched(3);
        for (i = 0; i < 3; i++)
            chk(32'(adp_mem_model_i.addr_q[i]), 32'(base + 19'(2 * i)));
        ahb(1, 12'h000, 32'h0001);
        repeat (40) @(posedge hclk);
        chk(32'(channel_active), 32'h0);
        chk(32'(channel_level[0]), 32'h0);
        adp_mem_model_i.addr_q.delete();
        ahb(1, 12'h000, 32'h8001);
        i = 0;
        while (channel_reload[0] !== 1'b1 && i < 8) begin @(negedge hclk); i++; end
        chk(32'(i < 8), 32'h1);
        fetched(1);
        chk(32'(adp_mem_model_i.addr_q[0]), 32'(base));
        ahb(1, 12'h000, 32'h0200);
        repeat (40) @(posedge hclk);
        n = adp_mem_model_i.addr_q.size();
        repeat (3000) @(posedge hclk);
        chk(32'(adp_mem_model_i.addr_q.size()), 32'(n));
        give_verdict;
    end
endmodule // tb_audio_dma_channel_playback
